/* verilog/pcbp_params.svh */
// Constants for the codec parallel bus port: control bit positions, reset values and encodings.
`ifndef PCBP_PARAMS_SVH
`define PCBP_PARAMS_SVH
`define PCBP_CR_RATE_LO       0
`define PCBP_CR_RATE_HI       1
`define PCBP_CR_DIG_LOOP      2
`define PCBP_CR_ANA_LOOP      3
`define PCBP_CR_PWR_DOWN      4
`define PCBP_CR_LAW_SEL       5
`define PCBP_CR_RESET         8'hFF
`define PCBP_CR_READ_ONES     8'hC0
`define PCBP_CR_STORE_MASK    8'h3F
`define PCBP_PCM_IDLE         8'hFF
`endif

/* verilog/pcbp_pkg.sv */
// Types shared by the codec parallel bus port.
package pcbp_pkg;
   typedef enum logic [1:0] {PCBP_RATE_1024K, PCBP_RATE_768K, PCBP_RATE_1280K} pcbp_rate_t;
   typedef enum logic [1:0] {PCBP_LOOP_NORMAL, PCBP_LOOP_ANALOG, PCBP_LOOP_DIGITAL} pcbp_loop_t;
   typedef enum logic [1:0] {PCBP_PWR_DOWN, PCBP_PWR_STANDBY, PCBP_PWR_ACTIVE} pcbp_pwr_t;

   // Codec-facing status that travels together.
   typedef struct packed {
      pcbp_pwr_t  pwr;
      pcbp_rate_t rate;
      pcbp_loop_t loop;
      logic       law_sel;
   } pcbp_mode_t;

   typedef struct packed {
      logic [1:0] rd_sync;
      logic [1:0] wr_sync;
      logic [1:0] frm_sync;
      logic [1:0] sel_sync;
      logic [7:0][1:0] db_sync;
      logic       rd_prev;
      logic       wr_prev;
      logic       frm_prev;
      logic [7:0] ctrl;
      logic [7:0] rx_hold;
      logic [7:0] dac_word;
      logic [7:0] tx_word;
      logic [7:0] db_out;
      logic [7:0] db_oe;
      logic       amp_oe;
      logic       seen_rd;
      logic       seen_wr;
      logic       frame_start;
      pcbp_mode_t mode;
   } pcbp_state_t;
endpackage : pcbp_pkg

/* verilog/pcbp_port.sv */
// Parallel host port of a PCM codec: strobes, mode/control register, power states and frame start.
//
// Notes on behaviour
// - Reset enters power-down with no host command.
// - Power-down floats the receive amplifier output, and the data lines except during a control read.
// - A control write clearing power-down brings the device to standby.
// - Coding starts only after a PCM read and a PCM write since power-up.
// - Rate bits: 0x gives 1.024 MHz, 10 gives 0.768 MHz, 11 gives 1.28 MHz.
// - Each frame sync pulse in the active state starts encode and decode together.
// - The read strobe enables the data line drivers, any time in the frame.
// - The write strobe captures the data lines, any time in the frame.
// - Select low targets PCM data, high targets the control register.
// - PCM sign bit is on line 0, least magnitude bit on line 7.
// - Power-down bit set powers down, clear powers up.
// - Bit 2 set is digital loopback, else bit 3 set is analog loopback.
// - Control read-back returns ones in the unused upper bits.
// - A written PCM word reaches the decoder at the next frame sync in the active state.
`timescale 1ns/1ps
`default_nettype none
`include "pcbp_params.svh"
module pcbp_port
   import pcbp_pkg::*;
(
   // Clock and reset.
   input  wire logic       mclk_in,
   input  wire logic       rst_b_in,
   // Host strobes and select, asynchronous to the clock.
   input  wire logic       read_in,
   input  wire logic       write_in,
   input  wire logic       pcm_or_ctrl_select_in,
   // Host data lines: inputs pass the synchronisers, outputs leave registers.
   input  wire logic [7:0] parallel_data_lines_in,
   output var  logic [7:0] parallel_data_lines_out,
   output var  logic [7:0] parallel_data_lines_oe_out,
   // Frame sync pin, active low.
   input  wire logic       frame_sync_n_in,
   // Encoder word from the codec core, on this clock.
   input  wire logic [7:0] enc_word_in,
   // Decoder word, frame start and amplifier enable to the codec core.
   output var  logic [7:0] dec_word_out,
   output var  logic       frame_start_out,
   output var  logic       receive_amp_output_oe_out,
   // Decoded operating mode.
   output var  pcbp_mode_t mode_out
);
   pcbp_state_t cur;
   pcbp_state_t next_cur;

   always_comb begin
      logic       rd_lvl;
      logic       wr_lvl;
      logic       frm_lvl;
      logic       sel;
      logic [7:0] db;
      logic       rd_rise;
      logic       wr_fall;
      logic       frm_fall;
      logic       powered;
      logic       ctrl_wr;
      logic       pcm_wr;
      logic       pcm_rd;
      logic       both_seen;
      logic       start_ok;
      logic [1:0] rate_bits;
      rd_lvl    = 1'b0;
      wr_lvl    = 1'b0;
      frm_lvl   = 1'b0;
      sel       = 1'b0;
      db        = 8'h00;
      rd_rise   = 1'b0;
      wr_fall   = 1'b0;
      frm_fall  = 1'b0;
      powered   = 1'b0;
      ctrl_wr   = 1'b0;
      pcm_wr    = 1'b0;
      pcm_rd    = 1'b0;
      both_seen = 1'b0;
      start_ok  = 1'b0;
      rate_bits = 2'b00;
      next_cur = cur;

      // Two-stage synchronisers for every host pin and for the frame sync pin.
      next_cur.rd_sync  = {cur.rd_sync[0], read_in};
      next_cur.wr_sync  = {cur.wr_sync[0], write_in};
      next_cur.frm_sync = {cur.frm_sync[0], frame_sync_n_in};
      next_cur.sel_sync = {cur.sel_sync[0], pcm_or_ctrl_select_in};
      for (int i = 0; i < 8; i++) begin
         next_cur.db_sync[i] = {cur.db_sync[i][0], parallel_data_lines_in[i]};
      end

      // Only the second stage of each synchroniser is read by the logic below.
      rd_lvl  = cur.rd_sync[1];
      wr_lvl  = cur.wr_sync[1];
      frm_lvl = cur.frm_sync[1];
      sel     = cur.sel_sync[1];
      for (int i = 0; i < 8; i++) begin
         db[i] = cur.db_sync[i][1];
      end
      next_cur.rd_prev  = rd_lvl;
      next_cur.wr_prev  = wr_lvl;
      next_cur.frm_prev = frm_lvl;

      // Each pin edge acts three clocks after the pin moves: two synchroniser stages and one edge stage.
      // Select and data pass the same two stages, so the host need only hold them steady across the write fall.
      rd_rise  = rd_lvl && !cur.rd_prev;
      wr_fall  = cur.wr_prev && !wr_lvl;
      frm_fall = cur.frm_prev && !frm_lvl;
      powered  = (cur.mode.pwr != PCBP_PWR_DOWN);
      ctrl_wr  = wr_fall && sel;
      pcm_wr   = wr_fall && !sel;
      pcm_rd   = rd_rise && !sel;

      // The write falling edge captures the bus, so the data has settled during the strobe.
      if (ctrl_wr) begin
         next_cur.ctrl = db & `PCBP_CR_STORE_MASK;
      end
      if (pcm_wr) begin
         next_cur.rx_hold = db;
      end
      // Accesses made in power-down do not count toward the start of coding.
      if (pcm_wr && powered) begin
         next_cur.seen_wr = 1'b1;
      end
      if (pcm_rd && powered) begin
         next_cur.seen_rd = 1'b1;
      end

      // Power state follows the stored power-down bit.
      both_seen = next_cur.seen_rd && next_cur.seen_wr;
      if (next_cur.ctrl[`PCBP_CR_PWR_DOWN]) begin
         next_cur.mode.pwr = PCBP_PWR_DOWN;
         next_cur.seen_rd  = 1'b0;
         next_cur.seen_wr  = 1'b0;
      end else if (!powered) begin
         next_cur.mode.pwr = PCBP_PWR_STANDBY;
      end else if (both_seen) begin
         next_cur.mode.pwr = PCBP_PWR_ACTIVE;
      end

      rate_bits = {next_cur.ctrl[`PCBP_CR_RATE_LO], next_cur.ctrl[`PCBP_CR_RATE_HI]};
      unique case (rate_bits)
         2'b00, 2'b01: next_cur.mode.rate = PCBP_RATE_1024K;
         2'b10:        next_cur.mode.rate = PCBP_RATE_768K;
         2'b11:        next_cur.mode.rate = PCBP_RATE_1280K;
      endcase
      if (next_cur.ctrl[`PCBP_CR_DIG_LOOP]) begin
         next_cur.mode.loop = PCBP_LOOP_DIGITAL;
      end else if (next_cur.ctrl[`PCBP_CR_ANA_LOOP]) begin
         next_cur.mode.loop = PCBP_LOOP_ANALOG;
      end else begin
         next_cur.mode.loop = PCBP_LOOP_NORMAL;
      end
      next_cur.mode.law_sel = next_cur.ctrl[`PCBP_CR_LAW_SEL];

      // Frame sync falling edge starts encode and decode in the same cycle.
      // A PCM access that meets the frame sync falling edge is not arbitrated here;
      // the host must keep the two apart.
      start_ok = frm_fall && (cur.mode.pwr == PCBP_PWR_ACTIVE);
      next_cur.frame_start = 1'b0;
      if (start_ok) begin
         next_cur.frame_start = 1'b1;
         next_cur.dac_word    = cur.rx_hold;
         next_cur.tx_word     = enc_word_in;
      end

      // Read drivers: control read works in any state, PCM read only when powered.
      next_cur.db_oe  = 8'h00;
      next_cur.db_out = 8'h00;
      if (rd_lvl) begin
         if (sel) begin
            next_cur.db_oe  = 8'hFF;
            next_cur.db_out = cur.ctrl | `PCBP_CR_READ_ONES;
         end else if (powered) begin
            next_cur.db_oe  = 8'hFF;
            // Digital loopback returns the held receive word in place of the encoder output.
            next_cur.db_out = (cur.mode.loop == PCBP_LOOP_DIGITAL) ? cur.rx_hold : cur.tx_word;
         end
      end
      // The receive amplifier is enabled whenever the device is out of power-down.
      next_cur.amp_oe = (next_cur.mode.pwr != PCBP_PWR_DOWN);
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         cur.rd_sync     <= 2'b00;
         cur.wr_sync     <= 2'b00;
         // Frame sync idles high, so its stages start high and no false frame edge follows reset.
         cur.frm_sync    <= 2'b11;
         cur.sel_sync    <= 2'b00;
         cur.db_sync     <= '0;
         cur.rd_prev     <= 1'b0;
         cur.wr_prev     <= 1'b0;
         cur.frm_prev    <= 1'b1;
         cur.ctrl        <= `PCBP_CR_RESET & `PCBP_CR_STORE_MASK;
         cur.rx_hold     <= `PCBP_PCM_IDLE;
         cur.dac_word    <= `PCBP_PCM_IDLE;
         cur.tx_word     <= `PCBP_PCM_IDLE;
         cur.db_out      <= 8'h00;
         cur.db_oe       <= 8'h00;
         cur.amp_oe      <= 1'b0;
         cur.seen_rd     <= 1'b0;
         cur.seen_wr     <= 1'b0;
         cur.frame_start <= 1'b0;
         // The decoded mode agrees with the stored reset value of the control register.
         cur.mode.pwr     <= PCBP_PWR_DOWN;
         cur.mode.rate    <= PCBP_RATE_1280K;
         cur.mode.loop    <= PCBP_LOOP_DIGITAL;
         cur.mode.law_sel <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign parallel_data_lines_out    = cur.db_out;
   assign parallel_data_lines_oe_out = cur.db_oe;
   assign dec_word_out               = cur.dac_word;
   assign frame_start_out            = cur.frame_start;
   assign receive_amp_output_oe_out  = cur.amp_oe;
   assign mode_out                   = cur.mode;
endmodule // pcbp_port
`default_nettype wire

/* tb/pcbp_port_checker.sv */
// Assertion checker bound to the codec parallel bus port.
`timescale 1ns/1ps
`default_nettype none
module pcbp_port_checker
   import pcbp_pkg::*;
(
   // Watched ports.
   input wire logic       mclk_in,
   input wire logic       rst_b_in,
   input wire logic       read_in,
   input wire logic       pcm_or_ctrl_select_in,
   input wire logic [7:0] parallel_data_lines_out,
   input wire logic [7:0] parallel_data_lines_oe_out,
   input wire logic [7:0] dec_word_out,
   input wire logic       frame_start_out,
   input wire logic       receive_amp_output_oe_out,
   input wire pcbp_mode_t mode_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   chk_amp_off: assert property (mode_out.pwr == PCBP_PWR_DOWN |-> !receive_amp_output_oe_out)
      else $error("amp on");
   chk_oe_whole: assert property (parallel_data_lines_oe_out inside {8'h00, 8'hFF})
      else $error("oe split");
   chk_read_cause: assert property ($rose(parallel_data_lines_oe_out[0]) |-> $past(read_in, 2))
      else $error("oe no read");
   chk_ctrl_ones: assert property ($rose(parallel_data_lines_oe_out[0]) && $past(pcm_or_ctrl_select_in, 2)
      |-> parallel_data_lines_out[7:6] == 2'b11) else $error("upper bits");
   chk_start_pulse: assert property (frame_start_out |=> !frame_start_out)
      else $error("long start");
   chk_start_active: assert property (frame_start_out |-> mode_out.pwr == PCBP_PWR_ACTIVE)
      else $error("early start");
   chk_dec_frame: assert property ($changed(dec_word_out) |-> frame_start_out)
      else $error("dec moved");
   chk_rate_cause: assert property ($changed(mode_out.rate) |-> $past(pcm_or_ctrl_select_in, 4))
      else $error("rate moved");
endmodule // pcbp_port_checker
bind pcbp_port pcbp_port_checker i_chk (.mclk_in, .rst_b_in, .read_in, .pcm_or_ctrl_select_in,
   .parallel_data_lines_out, .parallel_data_lines_oe_out, .dec_word_out, .frame_start_out,
   .receive_amp_output_oe_out, .mode_out);
`default_nettype wire

/* tb/pcbp_host.sv */
// Host bus model driving strobes, select and data lines of the port.
`timescale 1ns/1ps
`default_nettype none
module pcbp_host (
   // Bus pins.
   input  wire logic       mclk_in,
   output var  logic       read_out,
   output var  logic       write_out,
   output var  logic       sel_out,
   output var  logic [7:0] data_out,
   input  wire logic [7:0] bus_in,
   input  wire logic [7:0] bus_oe_in
);
   initial {read_out, write_out, sel_out, data_out} = 11'h100;
   task automatic wr(input logic s, input logic [7:0] d);
      @(negedge mclk_in);
      sel_out = s;
      data_out = d;
      write_out = 1'b1;
      repeat (3) @(negedge mclk_in);
      write_out = 1'b0;
      repeat (5) @(negedge mclk_in);
      data_out = ~d;
   endtask
   task automatic rd(input logic s, output logic [7:0] q);
      @(negedge mclk_in);
      sel_out = s;
      read_out = 1'b1;
      repeat (4) @(negedge mclk_in);
      q = (bus_oe_in == 8'hFF) ? bus_in : 8'hZZ;
      read_out = 1'b0;
      repeat (4) @(negedge mclk_in);
   endtask
endmodule // pcbp_host
`default_nettype wire

/* tb/tb_pcbp_port.sv */
// Self-checking testbench for the codec parallel bus port.
`timescale 1ns/1ps
`default_nettype none
module tb_pcbp_port;
   import pcbp_pkg::*;
   logic       mclk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic       frm_n = 1'b1;
   logic       rd, wr, sel, fst, amp;
   logic [7:0] hd, bus, oe, dec, q;
   pcbp_mode_t mode;
   int         err_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   // Frame sync period that gives 8 kHz at the 10 MHz clock.
   localparam int frame_cyc = 1250;
   always #50 mclk_in = ~mclk_in;
   always @(posedge mclk_in) cyc++;
   pcbp_port i_dut (.mclk_in, .rst_b_in, .read_in(rd), .write_in(wr), .pcm_or_ctrl_select_in(sel),
      .parallel_data_lines_in(hd), .parallel_data_lines_out(bus), .parallel_data_lines_oe_out(oe),
      .frame_sync_n_in(frm_n), .enc_word_in(8'h3C), .dec_word_out(dec), .frame_start_out(fst),
      .receive_amp_output_oe_out(amp), .mode_out(mode));
   pcbp_host i_host (.mclk_in, .read_out(rd), .write_out(wr), .sel_out(sel), .data_out(hd),
      .bus_in(bus), .bus_oe_in(oe));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk_mode(input logic [7:0] v, input pcbp_pwr_t p);
      pcbp_mode_t e;
      e = {p, !v[0] ? PCBP_RATE_1024K : (v[1] ? PCBP_RATE_1280K : PCBP_RATE_768K),
         v[2] ? PCBP_LOOP_DIGITAL : (v[3] ? PCBP_LOOP_ANALOG : PCBP_LOOP_NORMAL), v[5]};
      chk("mode", {1'b0, e}, {1'b0, mode});
      chk("amp", {7'h00, p != PCBP_PWR_DOWN}, {7'h00, amp});
   endtask
   task automatic frame(input logic exp);
      logic seen;
      seen = 1'b0;
      // Pulses start only on the fixed frame grid, so their rate stays steady.
      for (int n = 0; n < frame_cyc && (cyc % frame_cyc) != 0; n++) @(negedge mclk_in);
      frm_n = 1'b0;
      repeat (8) @(negedge mclk_in) seen |= fst;
      frm_n = 1'b1;
      chk("start", {7'h00, exp}, {7'h00, seen});
   endtask
   task automatic t_reset();
      chk_mode(8'h3F, PCBP_PWR_DOWN);
      i_host.rd(1'b1, q);
      chk("ctrl", 8'hFF, q);
      i_host.rd(1'b0, q);
      chk("pcm off", 8'hZZ, q);
   endtask
   task automatic t_modes();
      logic [7:0] v [4] = '{8'h10, 8'h19, 8'h37, 8'h1E};
      foreach (v[i]) begin
         i_host.wr(1'b1, v[i]);
         chk_mode(v[i], PCBP_PWR_DOWN);
         i_host.rd(1'b1, q);
         chk("ctrl", v[i] | 8'hC0, q);
      end
   endtask
   task automatic t_traffic();
      i_host.wr(1'b1, 8'h01);
      chk_mode(8'h01, PCBP_PWR_STANDBY);
      frame(1'b0);
      i_host.wr(1'b0, 8'hA5);
      chk("dec held", 8'hFF, dec);
      i_host.rd(1'b0, q);
      chk_mode(8'h01, PCBP_PWR_ACTIVE);
      frame(1'b1);
      chk("dec", 8'hA5, dec);
      i_host.rd(1'b0, q);
      chk("pcm", 8'h3C, q);
      i_host.wr(1'b1, 8'h05);
      chk_mode(8'h05, PCBP_PWR_ACTIVE);
      i_host.rd(1'b0, q);
      chk("loop", 8'hA5, q);
      i_host.wr(1'b1, 8'h11);
      chk_mode(8'h11, PCBP_PWR_DOWN);
   endtask
   task automatic close_out();
      if (err_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge mclk_in);
      rst_b_in = 1'b1;
      t_reset();
      t_modes();
      t_traffic();
      close_out();
   end
endmodule // tb_pcbp_port
`default_nettype wire
